// ==== core/dual_integrator_conversion_control.sv ====
`timescale 1ns/100ps

module dual_integrator_conversion_control #(
   parameter int SIDE_SELECT_CONVERT_CYCLES_P  = side_select_convert_ctrl_pkg::SIDE_SELECT_CONVERT_CYCLES,
   parameter int RESET_CYCLES_P = side_select_convert_ctrl_pkg::RESET_CYCLES
) (
   input  wire logic                                   sys_clk_in,
   input  wire logic                                   rstn_in,
   input  wire logic                                   clk_en_in,
   input  wire logic                                   side_select_convert_in,
   input  wire logic                                   range_sel_bit0_in,
   input  wire logic                                   range_sel_bit1_in,
   input  wire logic                                   range_sel_bit2_in,
   input  wire logic                                   serial_shift_clock_in,
   input  wire logic                                   transmit_enable_n_in,
   input  wire logic                                   cascade_serial_in,
   input  wire logic [side_select_convert_ctrl_pkg::RESULT_W-1:0]     adc_sample_in,
   output logic                                        side_a_integrate_switch_out,
   output logic                                        side_b_integrate_switch_out,
   output logic [1:0]                                  reference_connect_switch_out,
   output logic [1:0]                                  capacitor_clear_switch_out,
   output logic [1:0]                                  mux_select_out,
   output logic                                        converter_active_out,
   output logic [side_select_convert_ctrl_pkg::NUM_CAPS-1:0]          cap_select_out,
   output logic                                        ext_cap_enable_out,
   output logic                                        result_valid_n_out,
   output logic                                        serial_data_out,
   output logic                                        serial_data_oe_out
);
   import side_select_convert_ctrl_pkg::*;

   typedef struct packed {
      logic                side_select_convert_s1;
      logic                side_select_convert_s2;
      logic                side_select_convert_d;
      logic [RANGE_W-1:0]  rng_s1;
      logic [RANGE_W-1:0]  rng_s2;
      logic                sck_s1;
      logic                sck_s2;
      logic                sck_d;
      logic                txn_s1;
      logic                txn_s2;
      logic                din_s1;
      logic                din_s2;
      seq_state_t          state;
      logic                meas_side;
      logic                meas_ch;
      logic [TIMER_W-1:0]  timer;
      logic [RESULT_W-1:0] sample;
      logic [RESULT_W-1:0] sr;
      logic                sr_full;
      logic [BIT_CNT_W-1:0] bit_cnt;
      logic                int_a;
      logic                int_b;
      logic [1:0]          ref_sw;
      logic [1:0]          clr_sw;
      logic [1:0]          mux_sel;
      logic                side_select_convert_act;
      logic [NUM_CAPS-1:0] cap_sel;
      logic                ext_cap;
      logic                valid_n;
      logic                dout;
      logic                doe;
   } ctrl_state_t;

   ctrl_state_t st_reg;
   ctrl_state_t st_next;

   logic                fifo_wr_valid;
   logic                fifo_wr_ready;
   logic                fifo_rd_valid;
   logic                fifo_rd_ready;
   logic [RESULT_W-1:0] fifo_rd_data;
   logic                side_select_convert_edge;
   logic                sck_rise;
   logic                load;

   // Range code to one-hot capacitor select; code k enables capacitor k,
   // i.e. k times the unit step, and the external code enables none.
   function automatic logic [NUM_CAPS-1:0] cap_decode(input logic [RANGE_W-1:0] code);
      logic [NUM_CAPS-1:0] sel;
      sel = '0;
      for (int k = 1; k <= NUM_CAPS; k++) begin
         if (code == RANGE_W'(k)) begin
            sel[k-1] = 1'b1;
         end
      end
      return sel;
   endfunction

   // Converted words wait here so readout never blocks a conversion early;
   // when it fills, the sequencer holds in the push state.
   result_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (sys_clk_in),
      .rstn_in      (rstn_in),
      .en_in        (clk_en_in),
      .wr_valid_in  (fifo_wr_valid),
      .wr_ready_out (fifo_wr_ready),
      .wr_data_in   (st_reg.sample),
      .rd_valid_out (fifo_rd_valid),
      .rd_ready_in  (fifo_rd_ready),
      .rd_data_out  (fifo_rd_data)
   );

   // Next-state logic for synchronisers, sequencer, readout and outputs.
   always_comb begin
      st_next = st_reg;
      // Pins are double-registered; convert and serial clock add a third stage, read for edge detection.
      st_next.side_select_convert_s1 = side_select_convert_in;
      st_next.side_select_convert_s2 = st_reg.side_select_convert_s1;
      st_next.side_select_convert_d  = st_reg.side_select_convert_s2;
      st_next.rng_s1  = {range_sel_bit2_in, range_sel_bit1_in, range_sel_bit0_in};
      st_next.rng_s2  = st_reg.rng_s1;
      st_next.sck_s1  = serial_shift_clock_in;
      st_next.sck_s2  = st_reg.sck_s1;
      st_next.sck_d   = st_reg.sck_s2;
      st_next.txn_s1  = transmit_enable_n_in;
      st_next.txn_s2  = st_reg.txn_s1;
      st_next.din_s1  = cascade_serial_in;
      st_next.din_s2  = st_reg.din_s1;

      side_select_convert_edge     = st_reg.side_select_convert_s2 != st_reg.side_select_convert_d;
      fifo_wr_valid = 1'b0;

      // Measure the side that just stopped, one input after the other,
      // then recharge both of its capacitors. An edge while busy is not
      // queued: the controller must keep the integration period longer
      // than two conversions plus the recharge.
      case (st_reg.state)
         S_IDLE: begin
            if (side_select_convert_edge) begin
               st_next.meas_side = st_reg.side_select_convert_d;
               st_next.meas_ch   = 1'b0;
               st_next.timer     = TIMER_W'(SIDE_SELECT_CONVERT_CYCLES_P - 1);
               st_next.state     = S_MEASURE;
            end
         end
         S_MEASURE: begin
            if (st_reg.timer == '0) begin
               st_next.sample = adc_sample_in;
               st_next.state  = S_PUSH;
            end else begin
               st_next.timer = st_reg.timer - 1'b1;
            end
         end
         S_PUSH: begin
            fifo_wr_valid = 1'b1;
            if (fifo_wr_ready) begin
               if (st_reg.meas_ch) begin
                  st_next.timer = TIMER_W'(RESET_CYCLES_P - 1);
                  st_next.state = S_RESET;
               end else begin
                  st_next.meas_ch = 1'b1;
                  st_next.timer   = TIMER_W'(SIDE_SELECT_CONVERT_CYCLES_P - 1);
                  st_next.state   = S_MEASURE;
               end
            end
         end
         S_RESET: begin
            if (st_reg.timer == '0) begin
               st_next.state = S_IDLE;
            end else begin
               st_next.timer = st_reg.timer - 1'b1;
            end
         end
         default: begin
            st_next.state = S_IDLE;
         end
      endcase

      // Readout: load only while transmit is idle, shift only while it is
      // active, on rising serial clock edges seen by the system clock. The
      // serial clock must stay well below a quarter of the system clock.
      sck_rise      = st_reg.sck_s2 && !st_reg.sck_d;
      load          = st_reg.txn_s2 && !st_reg.sr_full && fifo_rd_valid;
      fifo_rd_ready = load;
      if (load) begin
         st_next.sr      = fifo_rd_data;
         st_next.sr_full = 1'b1;
         st_next.bit_cnt = '0;
      end else if (!st_reg.txn_s2 && sck_rise) begin
         // Upstream data keeps flowing through after our own word leaves.
         st_next.sr = {st_reg.sr[RESULT_W-2:0], st_reg.din_s2};
         if (st_reg.sr_full) begin
            if (st_reg.bit_cnt == BIT_CNT_W'(RESULT_W - 1)) begin
               st_next.sr_full = 1'b0;
               st_next.bit_cnt = '0;
            end else begin
               st_next.bit_cnt = st_reg.bit_cnt + 1'b1;
            end
         end
      end

      // Output registers.
      st_next.int_a    = st_reg.side_select_convert_s2;
      st_next.int_b    = !st_reg.side_select_convert_s2;
      st_next.ref_sw   = '0;
      st_next.clr_sw   = '0;
      if (st_reg.state == S_RESET) begin
         st_next.ref_sw[st_reg.meas_side] = 1'b1;
         st_next.clr_sw[st_reg.meas_side] = 1'b1;
      end
      st_next.mux_sel  = {st_reg.meas_ch, st_reg.meas_side};
      st_next.side_select_convert_act = st_reg.state == S_MEASURE;
      // A single select bus feeds all four integrators alike.
      st_next.cap_sel  = cap_decode(st_reg.rng_s2);
      st_next.ext_cap  = st_reg.rng_s2 == RANGE_EXTERNAL;
      st_next.valid_n  = !st_next.sr_full;
      st_next.dout     = st_next.sr[RESULT_W-1];
      st_next.doe      = !st_reg.txn_s2;
   end

   // All control state; async reset, frozen while the clock enable is low.
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg         <= '0;
         st_reg.side_select_convert_s1 <= SIDE_SELECT_CONVERT_RESET;
         st_reg.side_select_convert_s2 <= SIDE_SELECT_CONVERT_RESET;
         st_reg.side_select_convert_d  <= SIDE_SELECT_CONVERT_RESET;
         st_reg.txn_s1  <= TXN_RESET;
         st_reg.txn_s2  <= TXN_RESET;
         st_reg.state   <= S_IDLE;
         st_reg.int_b   <= 1'b1;
         st_reg.ext_cap <= 1'b1;
         st_reg.valid_n <= 1'b1;
      end else if (clk_en_in) begin
         st_reg <= st_next;
      end
   end

   // Every output comes straight from its register, so pins never glitch on decode.
   assign side_a_integrate_switch_out  = st_reg.int_a;
   assign side_b_integrate_switch_out  = st_reg.int_b;
   assign reference_connect_switch_out = st_reg.ref_sw;
   assign capacitor_clear_switch_out   = st_reg.clr_sw;
   assign mux_select_out               = st_reg.mux_sel;
   assign converter_active_out         = st_reg.side_select_convert_act;
   assign cap_select_out               = st_reg.cap_sel;
   assign ext_cap_enable_out           = st_reg.ext_cap;
   assign result_valid_n_out           = st_reg.valid_n;
   assign serial_data_out              = st_reg.dout;
   assign serial_data_oe_out           = st_reg.doe;

   // Length of the current measurement, for checking only.
   logic [TIMER_W-1:0] meas_len;
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meas_len <= '0;
      end else if (clk_en_in) begin
         meas_len <= (st_reg.state == S_MEASURE) ? meas_len + 1'b1 : '0;
      end
   end

   // Checks on what this block drives; all of them live on the system clock.
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rstn_in);

   side_a_start_a: assert property (
      clk_en_in && $rose(st_reg.side_select_convert_s2)
      |=> side_a_integrate_switch_out && !side_b_integrate_switch_out)
      else $error("side A did not start integrating after convert rose");

   one_side_int_a: assert property (
      clk_en_in |=> side_a_integrate_switch_out == $past(st_reg.side_select_convert_s2)
                    && side_b_integrate_switch_out != side_a_integrate_switch_out)
      else $error("integrate switches do not follow the convert level");

   meas_stopped_a: assert property (
      clk_en_in && st_reg.state == S_IDLE && st_reg.side_select_convert_s2 != st_reg.side_select_convert_d
      |=> st_reg.state == S_MEASURE && st_reg.meas_side != st_reg.side_select_convert_d)
      else $error("measurement did not pick the side that stopped");

   side_select_convert_length_a: assert property (
      clk_en_in && st_reg.state == S_MEASURE && st_next.state == S_PUSH
      |-> meas_len == TIMER_W'(SIDE_SELECT_CONVERT_CYCLES_P - 1))
      else $error("conversion length wrong");

   recharge_side_a: assert property (
      capacitor_clear_switch_out != 2'h0
      |-> reference_connect_switch_out == capacitor_clear_switch_out
          && capacitor_clear_switch_out[SIDE_A] != side_a_integrate_switch_out)
      else $error("recharge touched the integrating side");

   cap_onehot_a: assert property (
      $onehot0(cap_select_out) && (cap_select_out == 7'h00) == ext_cap_enable_out)
      else $error("capacitor select not one-hot or clashes with external");

   ext_cap_a: assert property (
      clk_en_in && st_reg.rng_s2 == RANGE_EXTERNAL |=> ext_cap_enable_out)
      else $error("external capacitors not selected for code zero");

   release_out_a: assert property (
      clk_en_in && st_reg.txn_s2 |=> !serial_data_oe_out)
      else $error("serial output driven while transmit high");

   hold_sr_a: assert property (
      clk_en_in && st_reg.txn_s2 && !load |=> $stable(st_reg.sr))
      else $error("shift register moved while transmit high");

   valid_load_a: assert property (
      clk_en_in && load |=> !result_valid_n_out [*1] ##0 st_reg.sr_full)
      else $error("valid did not go low after loading a result");

   both_push_a: assert property (
      clk_en_in && st_reg.state == S_PUSH && fifo_wr_ready && !st_reg.meas_ch
      |=> st_reg.state == S_MEASURE && st_reg.meas_ch)
      else $error("second input of the side was not measured");

   mux_side_a: assert property (
      converter_active_out |-> mux_select_out[0] != side_a_integrate_switch_out)
      else $error("converter measured the integrating side");

   shift_step_a: assert property (
      clk_en_in && !st_reg.txn_s2 && sck_rise
      |=> st_reg.sr == {$past(st_reg.sr[RESULT_W-2:0]), $past(st_reg.din_s2)})
      else $error("shift register did not advance on a serial clock edge");

   side_b_meas_c: cover property (st_reg.state == S_RESET && st_reg.meas_side == SIDE_B);
   side_a_meas_c: cover property (st_reg.state == S_RESET && st_reg.meas_side == SIDE_A);
   word_out_c:    cover property ($rose(result_valid_n_out));
   fifo_full_c:   cover property (fifo_wr_valid && !fifo_wr_ready);

endmodule

// ==== core/side_select_convert_ctrl_pkg.sv ====
package side_select_convert_ctrl_pkg;

   // Clock rate of the control logic, in MHz.
   localparam int SYS_CLK_MHZ   = 100;
   // Time taken by one 20-bit conversion, in microseconds.
   localparam int SIDE_SELECT_CONVERT_TIME_US  = 220;
   localparam int SIDE_SELECT_CONVERT_CYCLES   = SIDE_SELECT_CONVERT_TIME_US * SYS_CLK_MHZ;
   // Time the reference stays on the capacitor to recharge it, in ns.
   localparam int RESET_TIME_NS = 10000;
   localparam int RESET_CYCLES  = RESET_TIME_NS * SYS_CLK_MHZ / 1000;

   // Widths and depths.
   localparam int TIMER_W       = 16;
   localparam int RESULT_W      = 20;
   localparam int BIT_CNT_W     = 5;
   localparam int FIFO_DEPTH    = 8;
   localparam int RANGE_W       = 3;
   localparam int NUM_CAPS      = 7;

   // Range code that hands integration to the external capacitors.
   localparam logic [RANGE_W-1:0] RANGE_EXTERNAL = 3'h0;

   // Side encoding: the integrating side follows the convert level.
   localparam logic SIDE_A = 1'b1;
   localparam logic SIDE_B = 1'b0;

   // Reset values of the link-facing levels.
   localparam logic TXN_RESET   = 1'b1;
   localparam logic SIDE_SELECT_CONVERT_RESET  = 1'b0;

   // Conversion sequencer states.
   typedef enum logic [1:0] {
      S_IDLE    = 2'b00,
      S_MEASURE = 2'b01,
      S_PUSH    = 2'b10,
      S_RESET   = 2'b11
   } seq_state_t;

endpackage

// ==== core/result_fifo.sv ====
`timescale 1ns/100ps

module result_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             en_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          ov;
      logic [WIDTH-1:0] od;
   } fifo_state_t;

   fifo_state_t st_reg;
   fifo_state_t st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic take;

   // The head word sits in an output register so readers never see raw memory.
   always_comb begin
      push    = wr_valid_in && (st_reg.cnt != (AW+1)'(DEPTH));
      take    = (st_reg.cnt != '0) && (!st_reg.ov || rd_ready_in);
      st_next = st_reg;
      if (push) begin
         st_next.wp = st_reg.wp + 1'b1;
      end
      if (take) begin
         st_next.rp = st_reg.rp + 1'b1;
         st_next.od = mem[st_reg.rp];
         st_next.ov = 1'b1;
      end else if (rd_ready_in) begin
         st_next.ov = 1'b0;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(take);
   end

   // State register; the clock enable freezes everything.
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_reg <= '0;
      end else if (en_in) begin
         st_reg <= st_next;
      end
   end

   // Storage has no reset; only words already written are ever read.
   always_ff @(posedge clk_in) begin
      if (en_in && push) begin
         mem[st_reg.wp] <= wr_data_in;
      end
   end

   assign wr_ready_out = st_reg.cnt != (AW+1)'(DEPTH);
   assign rd_valid_out = st_reg.ov;
   assign rd_data_out  = st_reg.od;

endmodule

// ==== tb/side_select_convert_readout_model.sv ====
`timescale 1ns/100ps

// Controller stand-in on the readout side: it owns the serial clock, transmit and cascade.
module side_select_convert_readout_model (
   output logic      serial_shift_clock_out,
   output logic      transmit_enable_n_out,
   output logic      cascade_serial_out,
   input  wire logic serial_data_in,
   input  wire logic serial_data_oe_in,
   input  wire logic result_valid_n_in
);
   // The clock stands low between frames, and an unchained part keeps its cascade input low.
   initial begin
      serial_shift_clock_out = 1'b0;
      transmit_enable_n_out  = 1'b1;
      cascade_serial_out     = 1'b0;
   end

   // One frame of nbits, MSB first, at 125 ns; the odd start offset keeps every serial
   // edge clear of the system clock edges. A released line reads as unknown, not data.
   task automatic read_word(input int nbits, input logic casc_level,
                            output logic [39:0] w, output logic vn_end);
      w = '0;
      cascade_serial_out    = casc_level;
      transmit_enable_n_out = 1'b0;
      #401.2;
      for (int i = nbits - 1; i >= 0; i--) begin
         w[i] = serial_data_oe_in ? serial_data_in : 1'bx;
         serial_shift_clock_out = 1'b1;
         #62.5;
         serial_shift_clock_out = 1'b0;
         #62.5;
      end
      vn_end = result_valid_n_in;
      transmit_enable_n_out = 1'b1;
      cascade_serial_out    = 1'b0;
      #398.8;
   endtask

   // Clock pulses with transmit high, which the part must not act on; the offsets keep
   // the pulse edges away from the system clock edges.
   task automatic stray_clocks();
      #1.2;
      for (int i = 0; i < 8; i++) begin
         serial_shift_clock_out = 1'b1;
         #62.5;
         serial_shift_clock_out = 1'b0;
         #62.5;
      end
      #8.8;
   endtask
endmodule

// ==== tb/dual_integrator_conversion_control_bench.sv ====
`timescale 1ns/100ps

module dual_integrator_conversion_control_bench;
   import side_select_convert_ctrl_pkg::*;
   // Short counts keep the run brief; every expectation derives from these.
   localparam int SIDE_SELECT_CONVERT_N = 20;
   localparam int RST_N  = 5;
   logic                sys_clk_in = 1'b0;
   logic                rstn_in    = 1'b0;
   logic                side_select_convert       = 1'b0;
   logic                clk_en     = 1'b1;
   logic [RANGE_W-1:0]  range_code = 3'h0;
   logic [RESULT_W-1:0] adc        = 20'h00000;
   logic                sclk, txn, casc, sa, sb, act, ext, vn, sd, soe;
   logic [1:0]          refs, clrs, mux;
   logic [NUM_CAPS-1:0] caps;
   int                  miscompares = 0;
   int                  n_checks    = 0;

   always #5 sys_clk_in = ~sys_clk_in;

   dual_integrator_conversion_control #(.SIDE_SELECT_CONVERT_CYCLES_P(SIDE_SELECT_CONVERT_N), .RESET_CYCLES_P(RST_N)) dut_u (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en),
      .side_select_convert_in(side_select_convert), .range_sel_bit0_in(range_code[0]),
      .range_sel_bit1_in(range_code[1]), .range_sel_bit2_in(range_code[2]),
      .serial_shift_clock_in(sclk), .transmit_enable_n_in(txn), .cascade_serial_in(casc),
      .adc_sample_in(adc), .side_a_integrate_switch_out(sa), .side_b_integrate_switch_out(sb),
      .reference_connect_switch_out(refs), .capacitor_clear_switch_out(clrs),
      .mux_select_out(mux), .converter_active_out(act), .cap_select_out(caps),
      .ext_cap_enable_out(ext), .result_valid_n_out(vn), .serial_data_out(sd),
      .serial_data_oe_out(soe));

   side_select_convert_readout_model model_u (.serial_shift_clock_out(sclk), .transmit_enable_n_out(txn),
      .cascade_serial_out(casc), .serial_data_in(sd), .serial_data_oe_in(soe),
      .result_valid_n_in(vn));

   // Each integrator yields a word naming itself, so misordered or lost words show up.
   always @(negedge sys_clk_in) adc <= 20'h5A3C0 ^ {18'h0, mux};

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Levels held while reset is asserted.
   task automatic t_reset();
      check("side_a_rst", sa, 0);
      check("side_b_rst", sb, 1);
      check("valid_rst", vn, 1);
      check("oe_rst", soe, 0);
      check("caps_rst", caps, 0);
   endtask

   // Every range code, one select bus shared by all four integrators.
   task automatic t_range();
      for (int c = 0; c < 8; c++) begin
         @(negedge sys_clk_in) range_code = c[2:0];
         repeat (4) @(negedge sys_clk_in);
         check("cap_select", caps, (c == 0) ? 0 : (7'h01 << (c - 1)));
         check("ext_cap", ext, c == 0);
      end
   endtask

   // With the clock enable low a convert change must leave the side A switch frozen, and a
   // change undone before the enable returns must never start a conversion.
   task automatic t_freeze();
      int na = 0;
      @(negedge sys_clk_in) clk_en = 1'b0;
      side_select_convert = 1'b1;
      repeat (10) @(negedge sys_clk_in) na += act;
      check("frozen_side_a", sa, 0);
      side_select_convert = 1'b0;
      @(negedge sys_clk_in) clk_en = 1'b1;
      repeat (10) @(negedge sys_clk_in) na += act;
      check("frozen_no_convert", na, 0);
   endtask

   // One convert edge and the full measure and recharge of the side that stopped.
   task automatic side_select_convert_edge(logic v, logic [1:0] side_mux);
      int na = 0;
      int nr = 0;
      int nc = 0;
      int nw = 0;
      @(negedge sys_clk_in) side_select_convert = v;
      for (int i = 0; i < 85; i++) begin
         @(negedge sys_clk_in);
         if (i == 2) check("side_a_sw", sa, v);
         if (i == 2) check("side_b_sw", sb, !v);
         if (i == 4) check("mux_select", mux, side_mux);
         na += act;
         nr += refs[!v];
         nc += clrs[!v];
         nw += refs[v];
      end
      check("convert_cycles", na, 2 * SIDE_SELECT_CONVERT_N);
      check("recharge_cycles", nr, RST_N);
      check("clear_cycles", nc, RST_N);
      check("ref_on_integrator", nw, 0);
      check("still_integrating", sa, v);
   endtask

   // Ten words fit: eight in the buffer, one in its output stage, one in the shift
   // register. The eleventh stalls the sequencer in push, so that side is not recharged.
   task automatic t_full();
      int nr = 0;
      int na = 0;
      @(negedge sys_clk_in) side_select_convert = 1'b1;
      repeat (85) @(negedge sys_clk_in) nr += refs[0];
      check("last_fit_recharge", nr, RST_N);
      nr = 0;
      @(negedge sys_clk_in) side_select_convert = 1'b0;
      repeat (85) @(negedge sys_clk_in) begin
         nr += refs[1];
         na += act;
      end
      check("stalled_recharge", nr, 0);
      check("stalled_convert", na, SIDE_SELECT_CONVERT_N);
      check("side_b_busy", sb, 1);
   endtask

   // Drain all twelve words in order; stray clocks first must leave the first word
   // intact, and the last frame runs on through the cascade input as in a chain.
   task automatic t_readout();
      logic [39:0] w;
      logic        vn_end;
      logic [1:0]  m;
      check("oe_idle", soe, 0);
      model_u.stray_clocks();
      for (int k = 0; k < 12; k++) begin
         m = k[1:0];
         check("valid_before", vn, 0);
         if (k < 11) begin
            model_u.read_word(20, 1'b0, w, vn_end);
         end else begin
            model_u.read_word(40, 1'b1, w, vn_end);
            check("cascade_bits", w[19:0], 20'hFFFFF);
            w = w >> 20;
         end
         check("word", w[19:0], 20'h5A3C0 ^ {18'h0, m[0], m[1]});
         check("valid_after", vn_end, 1);
      end
      repeat (300) @(negedge sys_clk_in);
      check("valid_drained", vn, 1);
   endtask

   initial begin
      repeat (6) @(posedge sys_clk_in);
      t_reset();
      @(negedge sys_clk_in) rstn_in = 1'b1;
      t_range();
      t_freeze();
      side_select_convert_edge(1'b1, 2'h0);
      side_select_convert_edge(1'b0, 2'h1);
      side_select_convert_edge(1'b1, 2'h0);
      side_select_convert_edge(1'b0, 2'h1);
      t_full();
      t_readout();
      wrap_up();
   end

   // The tests take about 52 us; a hang is cut off well past that.
   initial begin
      #300000;
      miscompares++;
      wrap_up();
   end
endmodule
